// ### adc_id_status_mode_regs.sv
// Implementation choice: the AXI4-Lite slave port.
module adc_id_status_mode_regs #(
    parameter int ADDR_WIDTH = 8,
    parameter int PULSE_CYCLES = adc_regs_pkg::READY_PULSE_CYCLES,
    parameter logic [3:0] ID_HIGH_NIBBLE = 4'h0, // arbitrary value
    parameter logic [7:0] ID_LOW_BYTE = 8'h00 // arbitrary value
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // axi4-lite write
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter events, outside clock domain
    input wire logic interfaceLocked,
    input wire logic resyncEvent,
    input wire logic mapCrcChanged,
    input wire logic inputCrcError,
    input wire logic [2:0] newDataIn,
    // channel enables, same domain
    input wire logic [2:0] channelEnable,
    // setup outputs
    output logic regMapCrcEnable,
    output logic rxCrcEnable,
    output logic crcPolySelect,
    output logic [1:0] wordSizeSelect,
    output logic timeoutEnable,
    // conversion ready pin
    output logic conversionReadyPinOut,
    output logic conversionReadyPinOe
);

    if (ADDR_WIDTH < 4 || PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_param
        $error("unsupported parameter value");
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] addr);
        return addr[1:0] == 2'b00 && addr[ADDR_WIDTH-1:2] < (ADDR_WIDTH-2)'(adc_regs_pkg::REG_COUNT);
    endfunction

    function automatic logic [1:0] regIndex(input logic [ADDR_WIDTH-1:0] addr);
        return addr[3:2];
    endfunction

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    logic [6:0] syncStable;
    logic lockStable;
    logic resyncStable;
    logic mapCrcStable;
    logic crcErrStable;
    logic [2:0] newDataFlag;

    input_sync #(.WIDTH(7)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .rawIn({newDataIn, inputCrcError, mapCrcChanged, resyncEvent, interfaceLocked}),
        .stableOut(syncStable)
    );
    assign lockStable = syncStable[0];
    assign resyncStable = syncStable[1];
    assign mapCrcStable = syncStable[2];
    assign crcErrStable = syncStable[3];
    assign newDataFlag = syncStable[6:4];

    // ----------------------------------------------------------------
    // bus handshakes
    // ----------------------------------------------------------------
    logic awHeld, wHeld, next_awHeld, next_wHeld;
    logic [ADDR_WIDTH-1:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wrFire, rdFire;
    logic [ADDR_WIDTH-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [15:0] identityWord, conditionWord, setupWord;

    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        wrAddr = next_awAddr;
        wrData = next_wData;
        wrStrb = next_wStrb;
        wrFire = next_awHeld && next_wHeld && !s_axi_bvalid;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        if (wrFire) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = isMapped(wrAddr) ? adc_regs_pkg::RESP_OKAY : adc_regs_pkg::RESP_SLVERR;
        end
        next_awready = !next_awHeld && !next_bvalid;
        next_wready = !next_wHeld && !next_bvalid;
        rdFire = s_axi_arvalid && s_axi_arready;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (rdFire) begin
            next_rvalid = 1'b1;
            next_rresp = adc_regs_pkg::RESP_SLVERR;
            next_rdata = '0;
            if (isMapped(s_axi_araddr)) begin
                next_rresp = adc_regs_pkg::RESP_OKAY;
                unique case (regIndex(s_axi_araddr))
                    adc_regs_pkg::IDX_IDENTITY: next_rdata = {16'h0000, identityWord};
                    adc_regs_pkg::IDX_CONDITION: next_rdata = {16'h0000, conditionWord};
                    default: next_rdata = {16'h0000, setupWord};
                endcase
            end
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= '0;
            wStrb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= adc_regs_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= adc_regs_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // register contents
    // ----------------------------------------------------------------
    logic resyncFlag, crcErrFlag, resetFlag, leadLatch, resyncSeen, crcErrSeen;
    logic next_resyncFlag, next_crcErrFlag, next_resetFlag, next_leadLatch;
    logic [15:0] setupStore, next_setupStore;
    logic setupWrite, conditionRead;
    logic [15:0] laneMask;
    logic readyIdleFloat, readyPulseFormat;
    logic [1:0] readySourceSelect;

    assign identityWord = {ID_HIGH_NIBBLE, adc_regs_pkg::CHANNEL_TALLY, ID_LOW_BYTE};
    assign readySourceSelect = setupStore[adc_regs_pkg::SETUP_SOURCE_LSB +: 2];
    assign readyIdleFloat = setupStore[adc_regs_pkg::SETUP_FLOAT_BIT];
    assign readyPulseFormat = setupStore[adc_regs_pkg::SETUP_PULSE_BIT];

    always_comb begin
        conditionWord = '0;
        conditionWord[adc_regs_pkg::COND_LOCK_BIT] = lockStable;
        conditionWord[adc_regs_pkg::COND_RESYNC_BIT] = resyncFlag;
        conditionWord[adc_regs_pkg::COND_MAPCRC_BIT] = mapCrcStable && regMapCrcEnable;
        conditionWord[adc_regs_pkg::COND_CRCERR_BIT] = crcErrFlag;
        conditionWord[adc_regs_pkg::COND_POLY_BIT] = crcPolySelect;
        conditionWord[adc_regs_pkg::COND_RESET_BIT] = resetFlag;
        conditionWord[adc_regs_pkg::COND_WORD_LSB +: 2] = wordSizeSelect;
        conditionWord[2:0] = newDataFlag;
        setupWord = setupStore;
        setupWord[adc_regs_pkg::SETUP_RESET_BIT] = resetFlag;
    end

    always_comb begin
        laneMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};
        setupWrite = wrFire && isMapped(wrAddr) && regIndex(wrAddr) == adc_regs_pkg::IDX_SETUP;
        conditionRead = rdFire && isMapped(s_axi_araddr) && regIndex(s_axi_araddr) == adc_regs_pkg::IDX_CONDITION;
        next_setupStore = setupStore;
        if (setupWrite) begin
            laneMask = laneMask & adc_regs_pkg::SETUP_WRITE_MASK;
            next_setupStore = (setupStore & ~laneMask) | (wrData[15:0] & laneMask);
        end
        next_resetFlag = resetFlag;
        if (setupWrite && wrStrb[1] && !wrData[adc_regs_pkg::SETUP_RESET_BIT]) begin
            next_resetFlag = 1'b0;
        end
        next_resyncFlag = resyncFlag && !conditionRead;
        next_crcErrFlag = crcErrFlag && !conditionRead;
        if (resyncStable && !resyncSeen) begin
            next_resyncFlag = 1'b1;
        end
        if (crcErrStable && !crcErrSeen && rxCrcEnable) begin
            next_crcErrFlag = 1'b1;
        end
        next_leadLatch = |(newDataFlag & channelEnable);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            setupStore <= adc_regs_pkg::SETUP_RESET;
            resetFlag <= 1'b1;
            resyncFlag <= 1'b0;
            crcErrFlag <= 1'b0;
            resyncSeen <= 1'b0;
            crcErrSeen <= 1'b0;
            leadLatch <= 1'b0;
            regMapCrcEnable <= 1'b0;
            rxCrcEnable <= 1'b0;
            crcPolySelect <= 1'b0;
            wordSizeSelect <= adc_regs_pkg::SETUP_RESET[adc_regs_pkg::SETUP_WORD_LSB +: 2];
            timeoutEnable <= 1'b1;
        end else begin
            setupStore <= next_setupStore;
            resetFlag <= next_resetFlag;
            resyncFlag <= next_resyncFlag;
            crcErrFlag <= next_crcErrFlag;
            resyncSeen <= resyncStable;
            crcErrSeen <= crcErrStable;
            leadLatch <= next_leadLatch;
            regMapCrcEnable <= next_setupStore[adc_regs_pkg::SETUP_MAPCRC_BIT];
            rxCrcEnable <= next_setupStore[adc_regs_pkg::SETUP_RXCRC_BIT];
            crcPolySelect <= next_setupStore[adc_regs_pkg::SETUP_POLY_BIT];
            wordSizeSelect <= next_setupStore[adc_regs_pkg::SETUP_WORD_LSB +: 2];
            timeoutEnable <= next_setupStore[adc_regs_pkg::SETUP_TIMEOUT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // conversion ready pin
    // ----------------------------------------------------------------
    adc_regs_pkg::pin_state_type pinState, next_pinState;
    logic [7:0] pulseCount, next_pulseCount;
    logic readyCond, next_pinOut, next_pinOe;
    logic [2:0] enabledNew;

    always_comb begin
        enabledNew = newDataFlag & channelEnable;
        unique case (adc_regs_pkg::ready_source_type'(readySourceSelect))
            adc_regs_pkg::SRC_LAGGING: readyCond = (|channelEnable) && enabledNew == channelEnable;
            adc_regs_pkg::SRC_ANY: readyCond = |enabledNew;
            adc_regs_pkg::SRC_LEADING, adc_regs_pkg::SRC_LEADING_ALT: readyCond = leadLatch;
        endcase
        next_pinState = pinState;
        next_pulseCount = pulseCount;
        unique case (pinState)
            adc_regs_pkg::PIN_IDLE: begin
                if (readyCond) begin
                    next_pinState = readyPulseFormat ? adc_regs_pkg::PIN_PULSE : adc_regs_pkg::PIN_LOW;
                    next_pulseCount = 8'd0;
                end
            end
            adc_regs_pkg::PIN_LOW: begin
                if (!readyCond) begin
                    next_pinState = adc_regs_pkg::PIN_IDLE;
                end
            end
            adc_regs_pkg::PIN_PULSE: begin
                next_pulseCount = pulseCount + 8'd1;
                if (pulseCount == 8'(PULSE_CYCLES - 1)) begin
                    next_pinState = readyCond ? adc_regs_pkg::PIN_SPENT : adc_regs_pkg::PIN_IDLE;
                end
            end
            adc_regs_pkg::PIN_SPENT: begin
                if (!readyCond) begin
                    next_pinState = adc_regs_pkg::PIN_IDLE;
                end
            end
        endcase
        next_pinOut = !(next_pinState == adc_regs_pkg::PIN_LOW || next_pinState == adc_regs_pkg::PIN_PULSE);
        next_pinOe = !next_pinOut || !readyIdleFloat;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinState <= adc_regs_pkg::PIN_IDLE;
            pulseCount <= 8'd0;
            conversionReadyPinOut <= 1'b1;
            conversionReadyPinOe <= 1'b1;
        end else begin
            pinState <= next_pinState;
            pulseCount <= next_pulseCount;
            conversionReadyPinOut <= next_pinOut;
            conversionReadyPinOe <= next_pinOe;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    identity_tally_a: assert property (@(posedge sys_clk) disable iff (rst)
        rdFire && isMapped(s_axi_araddr) && regIndex(s_axi_araddr) == adc_regs_pkg::IDX_IDENTITY
        |=> s_axi_rdata[11:8] == 4'h3 && s_axi_rvalid)
        else $error("identity tally not three");
    lock_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        interfaceLocked [*5] |=> conditionWord[15])
        else $error("lock not reported");
    resync_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(resyncStable) |=> resyncFlag)
        else $error("resync flag not set");
    crc_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        !rxCrcEnable && !crcErrFlag |=> !crcErrFlag)
        else $error("crc error set while checking disabled");
    reset_after_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(rst) |-> resetFlag && timeoutEnable && !regMapCrcEnable && wordSizeSelect == 2'b01)
        else $error("reset values wrong");
    reset_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        setupWrite && wrStrb[1] && !wrData[10] |=> !resetFlag ##1 !conditionWord[10])
        else $error("reset flag not cleared");
    word_mirror_a: assert property (@(posedge sys_clk) disable iff (rst)
        conditionRead |=> s_axi_rdata[9:8] == $past(wordSizeSelect) && s_axi_rdata[11] == $past(crcPolySelect))
        else $error("word length mirror wrong");
    pulse_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(pinState == adc_regs_pkg::PIN_PULSE) |-> !conversionReadyPinOut [*8])
        else $error("pulse too short");
    idle_float_a: assert property (@(posedge sys_clk) disable iff (rst)
        conversionReadyPinOut && readyIdleFloat && $stable(readyIdleFloat) |-> !conversionReadyPinOe)
        else $error("idle pin driven while float selected");
    lag_source_a: assert property (@(posedge sys_clk) disable iff (rst)
        readySourceSelect == 2'b00 && enabledNew != channelEnable && pinState == adc_regs_pkg::PIN_IDLE
        |=> conversionReadyPinOut)
        else $error("lagging source asserted early");

endmodule

// ### adc_regs_pkg.sv
package adc_regs_pkg;

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [1:0] IDX_IDENTITY = 2'h0;
    localparam logic [1:0] IDX_CONDITION = 2'h1;
    localparam logic [1:0] IDX_SETUP = 2'h2;
    localparam int REG_COUNT = 3;

    // ----------------------------------------------------------------
    // identity fields
    // ----------------------------------------------------------------
    localparam int ID_TALLY_LSB = 8;
    localparam logic [3:0] CHANNEL_TALLY = 4'h3;

    // ----------------------------------------------------------------
    // condition fields
    // ----------------------------------------------------------------
    localparam int COND_LOCK_BIT = 15;
    localparam int COND_RESYNC_BIT = 14;
    localparam int COND_MAPCRC_BIT = 13;
    localparam int COND_CRCERR_BIT = 12;
    localparam int COND_POLY_BIT = 11;
    localparam int COND_RESET_BIT = 10;
    localparam int COND_WORD_LSB = 8;
    localparam logic [15:0] COND_RESET = 16'h0500;

    // ----------------------------------------------------------------
    // setup fields
    // ----------------------------------------------------------------
    localparam int SETUP_MAPCRC_BIT = 13;
    localparam int SETUP_RXCRC_BIT = 12;
    localparam int SETUP_POLY_BIT = 11;
    localparam int SETUP_RESET_BIT = 10;
    localparam int SETUP_WORD_LSB = 8;
    localparam int SETUP_TIMEOUT_BIT = 4;
    localparam int SETUP_SOURCE_LSB = 2;
    localparam int SETUP_FLOAT_BIT = 1;
    localparam int SETUP_PULSE_BIT = 0;
    localparam logic [15:0] SETUP_RESET = 16'h0510;
    localparam logic [15:0] SETUP_WRITE_MASK = 16'h3B1F;

    // ----------------------------------------------------------------
    // bus answers and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int READY_PULSE_CYCLES = 8;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        SRC_LAGGING = 2'b00,
        SRC_ANY = 2'b01,
        SRC_LEADING = 2'b10,
        SRC_LEADING_ALT = 2'b11
    } ready_source_type;

    typedef enum logic [1:0] {
        PIN_IDLE = 2'b00,
        PIN_LOW = 2'b01,
        PIN_PULSE = 2'b10,
        PIN_SPENT = 2'b11
    } pin_state_type;

endpackage

// ### conv_side.sv
module conv_side (
    // link clock
    input wire logic linkClk,
    // wanted event levels
    input wire logic [6:0] want,
    output logic [6:0] events,
    // ready pin
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial events = '0;
    always @(posedge linkClk) begin
        events <= want;
    end
    // pull-up on released pin
    assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule

// ### input_sync.sv
module input_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // raw and filtered levels
    input wire logic [WIDTH-1:0] rawIn,
    output logic [WIDTH-1:0] stableOut
);

    if (WIDTH < 1) begin : g_bad_width
        $error("input_sync width must be at least one");
    end

    // ----------------------------------------------------------------
    // three stages, change accepted when the last two agree
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic [adc_regs_pkg::SYNC_STAGES-1:0] stage;
            logic next_stable;
            always_comb begin
                next_stable = stableOut[i];
                if (stage[1] == stage[2]) begin
                    next_stable = stage[2];
                end
            end
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    stage <= '0;
                    stableOut[i] <= 1'b0;
                end else begin
                    stage <= {stage[1:0], rawIn[i]};
                    stableOut[i] <= next_stable;
                end
            end
        end
    endgenerate

endmodule

// ### tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, linkClk = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdat, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pinOut, pinOe, pinLevel;
    logic mapEn, rxEn, poly, tmo;
    logic [1:0] bresp, rresp, rs, wsz;
    logic [6:0] want = 0, ev;
    logic [2:0] chEn = 3'b111;
    int errors = 0, checks = 0, n;
    initial forever #2.5 sys_clk = ~sys_clk;
    initial forever #62.5 linkClk = ~linkClk;
    conv_side u_far (.linkClk(linkClk), .want(want), .events(ev), .pinOut(pinOut), .pinOe(pinOe),
        .pinLevel(pinLevel));
    adc_id_status_mode_regs #(.PULSE_CYCLES(8)) u_dut (.sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .interfaceLocked(ev[0]), .resyncEvent(ev[1]), .mapCrcChanged(ev[2]),
        .inputCrcError(ev[3]), .newDataIn(ev[6:4]), .channelEnable(chEn), .regMapCrcEnable(mapEn),
        .rxCrcEnable(rxEn), .crcPolySelect(poly), .wordSizeSelect(wsz), .timeoutEnable(tmo),
        .conversionReadyPinOut(pinOut), .conversionReadyPinOe(pinOe));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        forever begin
            @(posedge sys_clk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        rs = bresp;
        bready <= 0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        forever begin
            @(posedge sys_clk);
            if (arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        rdat = rdata;
        rs = rresp;
        rready <= 0;
        chk(rdat & m, exp);
        chk(32'(rs), 32'(er));
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #50000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 0;
        rdc(8'h00, 32'h0000_0300, 32'h0000_0F00, 2'h0);
        rdc(8'h04, 32'h0000_0500, 32'hFFFF_FFFF, 2'h0);
        rdc(8'h08, 32'h0000_0510, 32'hFFFF_FFFF, 2'h0);
        chk(32'({mapEn, rxEn, poly, wsz, tmo}), 32'h0000_0003);
        rdc(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF, 2'h2);
        wr(8'h00, 32'h0000_00FF);
        chk(32'(rs), 32'h0000_0000);
        rdc(8'h00, 32'h0000_0300, 32'h0000_0F00, 2'h0);
        $display("test reset and map done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, 32'h0000_0410 | (i << 8));
            rdc(8'h04, 32'h0000_0400 | (i << 8), 32'hFFFF_FFFF, 2'h0);
            chk(32'(wsz), i);
        end
        wr(8'h08, 32'h0000_3B0F);
        rdc(8'h08, 32'h0000_3B0F, 32'hFFFF_FFFF, 2'h0);
        rdc(8'h04, 32'h0000_0B00, 32'hFFFF_FFFF, 2'h0);
        chk(32'({mapEn, rxEn, poly, wsz, tmo}), 32'h0000_003E);
        $display("test setup done");
        want <= 7'b000_1111;
        repeat (60) @(posedge sys_clk);
        want <= 7'b000_0101;
        repeat (60) @(posedge sys_clk);
        rdc(8'h04, 32'h0000_FB00, 32'hFFFF_FFFF, 2'h0);
        rdc(8'h04, 32'h0000_AB00, 32'hFFFF_FFFF, 2'h0);
        chk(32'({pinOe, pinLevel}), 32'h0000_0001);
        $display("test events done");
        want <= 7'b000_1000;
        wr(8'h08, 32'h0000_0104);
        repeat (60) @(posedge sys_clk);
        chk(32'({pinOe, pinOut}), 32'h0000_0003);
        want <= 7'b001_0000;
        repeat (60) @(posedge sys_clk);
        chk(32'({pinOe, pinOut}), 32'h0000_0002);
        rdc(8'h04, 32'h0000_0101, 32'hFFFF_FFFF, 2'h0);
        wr(8'h08, 32'h0000_0100);
        repeat (4) @(posedge sys_clk);
        chk(32'(pinLevel), 32'h0000_0001);
        want <= 7'b111_0000;
        repeat (60) @(posedge sys_clk);
        chk(32'(pinLevel), 32'h0000_0000);
        rdc(8'h04, 32'h0000_0107, 32'hFFFF_FFFF, 2'h0);
        chEn <= 3'b011;
        want <= 7'b011_0000;
        repeat (60) @(posedge sys_clk);
        chk(32'(pinLevel), 32'h0000_0000);
        want <= 7'b000_0000;
        repeat (60) @(posedge sys_clk);
        wr(8'h08, 32'h0000_0101);
        want <= 7'b011_0000;
        n = 0;
        repeat (150) begin
            @(posedge sys_clk);
            if (pinLevel === 1'b0) n++;
        end
        chk(n, 8);
        want <= 7'b000_0000;
        wr(8'h08, 32'h0000_0108);
        repeat (60) @(posedge sys_clk);
        want <= 7'b010_0000;
        repeat (60) @(posedge sys_clk);
        chk(32'(pinLevel), 32'h0000_0000);
        $display("test ready pin done");
        end_of_test();
    end
endmodule
